// ---- logic/abhp_pkg.sv ----
/*
 * abhp_pkg: shared types and constants for the byte-wide host port.
 * Assumes one 250 MHz system clock; host pins are asynchronous to it.
 */
package abhp_pkg;

	// host-side pin bundle as seen by the device
	typedef struct packed {
		logic cs_n;      // chip select, active low
		logic rd_n;      // read strobe, active low
		logic wr_n;      // store strobe, active low
		logic hbs;       // high_byte_select
		logic [11:0] db; // data pins, bit 0 is data_pin_lsb
	} abhp_pins_t;

	// assembled write word handed to the core
	typedef struct packed {
		logic valid;
		logic [15:0] word;
	} abhp_wr_t;

	// write assembly states, gray along empty -> low held
	typedef enum logic {
		ABHP_W_EMPTY = 1'b0,
		ABHP_W_LOW = 1'b1
	} abhp_wstate_t;

	localparam int ABHP_DATA_W = 12;
	localparam int ABHP_BYTE_W = 8;
	localparam int ABHP_WORD_W = 16;
	localparam int ABHP_SYNC_STAGES = 2;
	// pins idle: strobes high, select low, data low
	localparam abhp_pins_t ABHP_PINS_IDLE = 16'he000;
	// word that restores the test register to its default
	localparam logic [15:0] ABHP_TEST_RESTORE = 16'h4002;
	localparam logic [11:0] ABHP_DB_RESET = 12'h000;
	localparam logic [7:0] ABHP_BYTE_RESET = 8'h00;
	localparam logic [15:0] ABHP_WORD_RESET = 16'h0000;

endpackage : abhp_pkg

// ---- logic/abhp_sync.sv ----
/*
 * abhp_sync: two-stage synchroniser for a vector of host pins.
 * Assumes each bit is a level; the first stage is read only by the second.
 */
`timescale 1ns/1ps
module abhp_sync
	import abhp_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// asynchronous in, synchronous out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;

	// two flops in series
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_ff <= RST_VAL;
			sync_out <= RST_VAL;
		end
		else
		begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule : abhp_sync

// ---- logic/abhp_port.sv ----
/*
 * abhp_port: byte-wide parallel host port of a sampling converter.
 * Assumes host pins are asynchronous and slow against the 250 MHz clock;
 * the core supplies the selected 16-bit read word and takes written words.
 */
// Notes on behaviour
// - each 16-bit word arrives as two byte writes and is assembled here
// - select low gives the low byte, select high the upper byte
// - upper four data pins are ignored on writes
// - write happens only while chip select and store strobe are both low
// - write byte is captured on the rising edge of the store strobe
// - writes are taken whether or not a conversion is running
// - on a 12-bit bus one read at base gives result or status
// - select low on read drives the low twelve bits on all data pins
// - select high on read drives the upper byte on the low eight pins
// - read data is driven only while chip select and read are low
// - data pins are released once the read strobe returns high
`timescale 1ns/1ps
module abhp_port
	import abhp_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// host pins
	input wire abhp_pins_t host_pins,
	output logic [ABHP_DATA_W-1:0] db_out,
	output logic db_oe,
	// core side
	input wire logic [ABHP_WORD_W-1:0] rd_word,
	input wire logic conv_busy,
	output abhp_wr_t wr_data,
	output logic test_restore
);

	abhp_pins_t pin_s;
	abhp_wstate_t state_ff;
	abhp_wstate_t nxt_state;
	logic wr_act_ff;
	logic [ABHP_BYTE_W-1:0] byte_hold_ff;
	logic hbs_hold_ff;
	logic [ABHP_BYTE_W-1:0] lo_byte_ff;
	logic [ABHP_BYTE_W-1:0] nxt_lo_byte;
	logic [ABHP_DATA_W-1:0] nxt_db;
	logic [ABHP_WORD_W-1:0] asm_word;

	// synchronise every host pin before use
	abhp_sync #(
		.WIDTH($bits(abhp_pins_t)),
		.RST_VAL(ABHP_PINS_IDLE)
	) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.async_in(host_pins),
		.sync_out(pin_s)
	);

	// strobe decode
	// gate select with strobes
	wire wr_act = ~pin_s.cs_n & ~pin_s.wr_n;
	wire rd_act = ~pin_s.cs_n & ~pin_s.rd_n;
	wire wr_rise = wr_act_ff & ~wr_act;
	wire take_low = wr_rise & ~hbs_hold_ff;
	wire take_high = wr_rise & hbs_hold_ff & (state_ff == ABHP_W_LOW);
	assign asm_word = {byte_hold_ff, lo_byte_ff};

	// write assembly next state
	always_comb
	begin
		nxt_state = state_ff;
		nxt_lo_byte = lo_byte_ff;
		case (state_ff)
			ABHP_W_EMPTY:
			begin
				if (take_low)
				begin
					nxt_state = ABHP_W_LOW;
					nxt_lo_byte = byte_hold_ff;
				end
			end
			ABHP_W_LOW:
			begin
				if (take_low)
					nxt_lo_byte = byte_hold_ff;
				else if (take_high)
					nxt_state = ABHP_W_EMPTY;
			end
			default:
			begin
				nxt_state = ABHP_W_EMPTY;
			end
		endcase
	end

	assign nxt_db = pin_s.hbs ? {4'h0, rd_word[15:8]} : rd_word[11:0];

	// hold byte and select while the write strobe is active
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_act_ff <= 1'b0;
			byte_hold_ff <= ABHP_BYTE_RESET;
			hbs_hold_ff <= 1'b0;
		end
		else
		begin
			wr_act_ff <= wr_act;
			if (wr_act)
			begin
				byte_hold_ff <= pin_s.db[7:0];
				hbs_hold_ff <= pin_s.hbs;
			end
		end
	end

	// state, low byte and word output
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_ff <= ABHP_W_EMPTY;
			lo_byte_ff <= ABHP_BYTE_RESET;
			wr_data <= '{valid: 1'b0, word: ABHP_WORD_RESET};
			test_restore <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			lo_byte_ff <= nxt_lo_byte;
			wr_data.valid <= take_high;
			if (take_high)
				wr_data.word <= asm_word;
			test_restore <= take_high & (asm_word == ABHP_TEST_RESTORE);
		end
	end

	// read drivers
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			db_out <= ABHP_DB_RESET;
			db_oe <= 1'b0;
		end
		else
		begin
			db_oe <= rd_act;
			// low 12 bits, or the upper byte when select is high
			db_out <= nxt_db;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_write_end;
		wr_act_ff ##0 !wr_act;
	endsequence

	sequence s_high_end;
		s_write_end ##0 hbs_hold_ff ##0 (state_ff == ABHP_W_LOW);
	endsequence

	a_word_assembly: assert property (s_high_end |=> wr_data.valid &&
		wr_data.word == {$past(byte_hold_ff), $past(lo_byte_ff)})
		else $error("assembled word wrong or missing");

	a_low_byte_stored: assert property ((wr_rise && !hbs_hold_ff) |=>
		lo_byte_ff == $past(byte_hold_ff) && state_ff == ABHP_W_LOW && !wr_data.valid)
		else $error("low byte not stored");

	a_upper_ignored: assert property (wr_act |=> byte_hold_ff == $past(pin_s.db[7:0]))
		else $error("write byte not from low pins");

	a_cs_gates_write: assert property ($past(pin_s.cs_n, 2) |-> !wr_data.valid)
		else $error("word issued without chip select");

	a_capture_on_rise: assert property (wr_data.valid |-> $past(wr_act_ff) && !$past(wr_act))
		else $error("word issued without strobe rising edge");

	a_busy_ignored: assert property ((s_high_end ##0 conv_busy) |=> wr_data.valid)
		else $error("write lost during conversion");

	a_read_low: assert property ((db_oe && !$past(pin_s.hbs)) |->
		db_out == $past(rd_word[11:0]))
		else $error("low read data wrong");

	a_read_high: assert property ((db_oe && $past(pin_s.hbs)) |->
		db_out == {4'h0, $past(rd_word[15:8])})
		else $error("high read data wrong");

	a_read_enable: assert property (rd_act [*2] |-> db_oe [*2])
		else $error("data not driven during read");

	a_read_release: assert property ($past(pin_s.rd_n) |-> !db_oe)
		else $error("data pins still driven after read");

	a_low_held: assert property ((state_ff == ABHP_W_LOW && !wr_rise) |=>
		$stable(lo_byte_ff) && state_ff == ABHP_W_LOW && !wr_data.valid)
		else $error("held low byte lost");

endmodule : abhp_port

// ---- tb/abhp_host.sv ----
/*
 * abhp_host: behavioural host processor on the byte-wide port.
 * Assumes the bench calls its tasks from one process, on the clock edge.
 */
`timescale 1ns/1ps
module abhp_host
	import abhp_pkg::*;
(
	// clock
	input wire logic sys_clk,
	// pins towards the device
	output abhp_pins_t pins,
	input wire logic [ABHP_DATA_W-1:0] db_out,
	input wire logic db_oe
);
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic hbs = 1'b0;
	logic [11:0] hdb = 12'h000;
	// resolved data wire, device wins while enabled
	assign pins = '{cs_n, rd_n, wr_n, hbs, db_oe ? db_out : hdb};
	task automatic wr(input logic sel, input logic cs, input logic [11:0] d);
		@(posedge sys_clk);
		cs_n <= ~cs;
		wr_n <= 1'b0;
		hbs <= sel;
		hdb <= d;
		// strobe held as with wait states
		repeat (4) @(posedge sys_clk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		hdb <= ~d; // released bus shows the inverse
	endtask : wr
	task automatic rd(input logic sel, input logic cs, output logic [11:0] d,
		output logic on, output logic off);
		@(posedge sys_clk);
		cs_n <= ~cs;
		rd_n <= 1'b0;
		hbs <= sel;
		repeat (5) @(posedge sys_clk);
		#1 d = pins.db;
		on = db_oe;
		@(posedge sys_clk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		#1 off = db_oe;
		@(posedge sys_clk);
	endtask : rd
endmodule : abhp_host

// ---- tb/tb_abhp_port.sv ----
/*
 * tb_abhp_port: self-checking bench for the byte-wide host port.
 * Assumes the host model drives all pins; words are checked from a queue.
 */
`timescale 1ns/1ps
module tb_abhp_port;
	import abhp_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic conv_busy = 1'b0;
	logic [15:0] rd_word = 16'h0000;
	abhp_pins_t host_pins;
	logic [11:0] db_out;
	logic db_oe;
	abhp_wr_t wr_data;
	logic test_restore;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [16:0] exp_q[$];
	logic [16:0] e;
	logic [11:0] d;
	logic on;
	logic off;
	abhp_port abhp_port_inst (.sys_clk(sys_clk), .resetn(resetn), .host_pins(host_pins),
		.db_out(db_out), .db_oe(db_oe), .rd_word(rd_word), .conv_busy(conv_busy),
		.wr_data(wr_data), .test_restore(test_restore));
	abhp_host abhp_host_inst (.sys_clk(sys_clk), .pins(host_pins), .db_out(db_out),
		.db_oe(db_oe));
	initial
	begin
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [16:0] got, input logic [16:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic test_done();
		$display("comparisons=%0d failures=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	// note the word, then send it as two bytes with junk on the top pins
	task automatic word(input logic [15:0] w);
		exp_q.push_back({w == ABHP_TEST_RESTORE, w});
		abhp_host_inst.wr(1'b0, 1'b1, {4'($urandom), w[7:0]});
		abhp_host_inst.wr(1'b1, 1'b1, {4'($urandom), w[15:8]});
	endtask : word
	// watcher: each written word against the oldest note, plus the timeout
	always @(negedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (wr_data.valid === 1'b1)
		begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1ffff;
			check({test_restore, wr_data.word}, e);
		end
		if (cycles == 20000)
		begin
			failures++;
			test_done();
		end
	end
	initial
	begin
		void'($urandom(69316));
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (6)
		begin
			// busy as the core's conversion flag
			conv_busy <= 1'($urandom);
			word(16'($urandom));
		end
		// restore word sent while a conversion runs
		conv_busy <= 1'b1;
		word(ABHP_TEST_RESTORE);
		conv_busy <= 1'b0;
		$display("test random words done");
		// orphan high dropped, second low replaces, gated low ignored
		abhp_host_inst.wr(1'b1, 1'b1, 12'h0a5);
		abhp_host_inst.wr(1'b0, 1'b1, 12'h033);
		exp_q.push_back(17'h05c77);
		abhp_host_inst.wr(1'b0, 1'b1, 12'h077);
		abhp_host_inst.wr(1'b0, 1'b0, 12'h0ee);
		abhp_host_inst.wr(1'b1, 1'b1, 12'h05c);
		$display("test write order done");
		// reads of both halves, then one with chip select high
		for (int i = 0; i < 4; i++)
		begin
			rd_word <= 16'($urandom);
			abhp_host_inst.rd(i[0], 1'b1, d, on, off);
			check({4'h0, on, d}, i[0] ? {9'h010, rd_word[15:8]} : {5'h01, rd_word[11:0]});
			check({16'h0, off}, 17'h0);
		end
		abhp_host_inst.rd(1'b0, 1'b0, d, on, off);
		check({16'h0, on}, 17'h0);
		$display("test reads done");
		repeat (10) @(posedge sys_clk);
		check(17'(exp_q.size()), 17'h0);
		test_done();
	end
endmodule : tb_abhp_port
